// ---- tb/gpe_board.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpe_board (
  // clock
  input  wire logic       clk_i,
  // device side
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  input  wire logic [7:0] pull_up_o,
  // board drivers
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  // resolved pins
  output logic      [7:0] pin_i
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge clk_i) last_r <= pin_i;
  // floating pins flip each cycle unless pulled up
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ((ext_en_i & ext_val_i)
                 | (~ext_en_i & (pull_up_o | ~last_r))));
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gpe_regs.svh"
module tb
  import gpe_pkg::*;
;
  logic       clk_i, rst_i, cyc, stb, we, ack, err, bad;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  gpe_byte_t  pin, pout, poe, pup, pdn, slw, drv, ext_val, ext_en, rd, eff;
  gpe_byte_t  d, v, p, s, g, x, e;
  logic [55:0] rows [4];
  int         num_errors = 0;
  int         n_checks = 0;
  gpe_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .pin_i(pin), .pin_o(pout), .pin_oe_o(poe),
    .pull_up_o(pup), .pull_down_o(pdn), .slew_o(slw), .drive_o(drv));
  gpe_board u_board (.clk_i(clk_i), .pin_o(pout), .pin_oe_o(poe), .pull_up_o(pup),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_i(pin));
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] dv, input logic [3:0] sv);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h000000, dv}; sel <= sv;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      give_verdict;
    end
    rd = rdat[7:0];
    bad = err;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    wdat = 32'h00000000; ext_val = 8'h00; ext_en = 8'hff;
    rows[0] = 56'hff_a5_ff_ff_ff_00_a5;
    rows[1] = 56'h00_3c_0f_f0_55_5a_5a;
    rows[2] = 56'h0f_96_f0_33_cc_c3_c6;
    rows[3] = 56'h02_ff_02_02_02_00_00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({poe, pout, pup, pdn, slw, drv}, 64'h0);
    for (int a = 0; a <= 16; a += 4) begin
      wb(1'b0, 8'(a), 8'h00, 4'hf);
      chk(rd, 8'h00);
    end
    $display("reset test done");
    for (int r = 0; r < 4; r++) begin
      {d, v, p, s, g, x, e} = rows[r];
      ext_val <= x;
      wb(1'b1, `GPE_OFS_DIR, d, 4'hf);
      wb(1'b1, `GPE_OFS_VALUE, v, 4'hf);
      wb(1'b1, `GPE_OFS_PULL, p, 4'hf);
      wb(1'b1, `GPE_OFS_SLEW, s, 4'hf);
      wb(1'b1, `GPE_OFS_DRIVE, g, 4'hf);
      eff = d & ~`GPE_IN_ONLY_MSK;
      chk({poe, pout, pup, pdn, slw, drv}, {eff, v & eff, p & ~eff, 8'h00, s & eff, g & eff});
      repeat (4) @(posedge clk_i);
      wb(1'b0, `GPE_OFS_VALUE, 8'h00, 4'hf);
      chk(rd, e);
      wb(1'b0, `GPE_OFS_DIR, 8'h00, 4'hf);
      chk(rd, d);
      $display("row %0d done", r);
    end
    ext_val <= 8'h00;
    wb(1'b1, `GPE_OFS_DIR, 8'h00, 4'hf);
    wb(1'b1, `GPE_OFS_VALUE, 8'h6b, 4'hf);
    wb(1'b1, `GPE_OFS_DIR, 8'hff, 4'hf);
    repeat (4) @(posedge clk_i);
    wb(1'b0, `GPE_OFS_VALUE, 8'h00, 4'hf);
    chk(rd, 8'h69);
    wb(1'b1, `GPE_OFS_DIR, 8'h00, 4'h0);
    wb(1'b1, 8'h14, 8'h00, 4'hf);
    chk(bad, 1'b1);
    wb(1'b0, `GPE_OFS_DIR, 8'h00, 4'hf);
    chk(rd, 8'hff);
    $display("latch and refusal test done");
    wb(1'b1, `GPE_OFS_DIR, 8'h00, 4'hf);
    wb(1'b1, `GPE_OFS_PULL, 8'h0f, 4'hf);
    ext_en <= 8'h00;
    repeat (4) @(posedge clk_i);
    wb(1'b0, `GPE_OFS_VALUE, 8'h00, 4'hf);
    chk(rd[3:0], 4'hf);
    ext_en <= 8'hff;
    wb(1'b1, `GPE_OFS_DIR, 8'hff, 4'hf);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({poe, pout, pup, pdn, slw, drv}, 64'h0);
    wb(1'b0, `GPE_OFS_DIR, 8'h00, 4'hf);
    chk(rd, 8'h00);
    $display("pull and second reset test done");
    give_verdict;
  end
endmodule
`default_nettype wire

// ---- verilog/gpe_pkg.sv ----
package gpe_pkg;
  typedef logic [7:0] gpe_byte_t;
endpackage

// ---- verilog/gpe_port.sv ----
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "gpe_regs.svh"
module gpe_port
  import gpe_pkg::*;
(
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // pins
  input  wire logic [7:0]  pin_i,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_o,
  output logic      [7:0]  pull_up_o,
  output logic      [7:0]  pull_down_o,
  output logic      [7:0]  slew_o,
  output logic      [7:0]  drive_o
);

  gpe_byte_t value_r;
  gpe_byte_t dir_r;
  gpe_byte_t pull_r;
  gpe_byte_t slew_r;
  gpe_byte_t drive_r;
  gpe_byte_t sync1_r;
  gpe_byte_t sync2_r;
  gpe_byte_t sync3_r;
  gpe_byte_t level_r;

  function automatic logic gpe_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return (adr == ofs);
  endfunction

  // outputs change on the same edge as the register write
  wire       req       = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire       hit_value = gpe_hit(wb_adr_i, `GPE_OFS_VALUE);
  wire       hit_dir   = gpe_hit(wb_adr_i, `GPE_OFS_DIR);
  wire       hit_pull  = gpe_hit(wb_adr_i, `GPE_OFS_PULL);
  wire       hit_slew  = gpe_hit(wb_adr_i, `GPE_OFS_SLEW);
  wire       hit_drive = gpe_hit(wb_adr_i, `GPE_OFS_DRIVE);
  wire       hit_any   = hit_value | hit_dir | hit_pull | hit_slew | hit_drive;
  wire       wr        = req & wb_we_i & wb_sel_i[0];
  wire [7:0] wbyte     = wb_dat_i[7:0];

  // pin 1 has no driver, so its direction bit is masked
  wire [7:0] dir_eff   = dir_r & ~`GPE_IN_ONLY_MSK;
  wire [7:0] dir_nxt   = (wr && hit_dir) ? wbyte : dir_r;
  wire [7:0] val_nxt   = (wr && hit_value) ? wbyte : value_r;
  wire [7:0] pull_nxt  = (wr && hit_pull) ? wbyte : pull_r;
  wire [7:0] slew_nxt  = (wr && hit_slew) ? wbyte : slew_r;
  wire [7:0] drv_nxt   = (wr && hit_drive) ? wbyte : drive_r;
  wire [7:0] deff_nxt  = dir_nxt & ~`GPE_IN_ONLY_MSK;

  // read mux: latch on outputs, pin on inputs and bit 1 always
  wire [7:0] value_rd  = (value_r & dir_eff) | (level_r & ~dir_eff);
  wire [7:0] rd_byte   = hit_value ? value_rd :
                         hit_dir   ? dir_r :
                         hit_pull  ? pull_r :
                         hit_slew  ? slew_r :
                         hit_drive ? drive_r : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_r <= `GPE_RST_VALUE;
      dir_r   <= `GPE_RST_DIR;
      pull_r  <= `GPE_RST_PULL;
      slew_r  <= `GPE_RST_SLEW;
      drive_r <= `GPE_RST_DRIVE;
    end else begin
      value_r <= val_nxt;
      dir_r   <= dir_nxt;
      pull_r  <= pull_nxt;
      slew_r  <= slew_nxt;
      drive_r <= drv_nxt;
    end
  end

  // three-stage synchroniser, level changes when stages 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      sync3_r <= 8'h00;
      level_r <= 8'h00;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= (sync2_r & sync3_r) | (level_r & (sync2_r | sync3_r));
    end
  end

  // pin controls registered from next values, valid at the edge after a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o       <= 8'h00;
      pin_oe_o    <= 8'h00;
      pull_up_o   <= 8'h00;
      pull_down_o <= 8'h00;
      slew_o      <= 8'h00;
      drive_o     <= 8'h00;
    end else begin
      pin_o       <= val_nxt & deff_nxt;
      pin_oe_o    <= deff_nxt;
      pull_up_o   <= pull_nxt & ~deff_nxt;
      pull_down_o <= 8'h00;
      slew_o      <= slew_nxt & deff_nxt;
      drive_o     <= drv_nxt & deff_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & hit_any;
      wb_err_o <= req & ~hit_any;
      wb_dat_o <= (req && !wb_we_i && hit_any) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // bus answer timing
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  err_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_err_o |=> !wb_err_o)
    else $error("err held longer than one cycle");
  ack_err_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  ack_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && hit_any) |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acknowledged");
  err_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !hit_any) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(req && hit_any))
    else $error("ack without a request");
  idle_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o && !wb_err_o)
    else $error("answer without a request");
  idle_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> wb_dat_o == 32'h0000_0000)
    else $error("read data without a request");
  dat_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  dat_wr_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i) |=> wb_dat_o == 32'h0000_0000)
    else $error("read data on a write");
  err_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_err_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data on a refused access");

  // register writes
  wr_val_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_value) |=> (value_r == $past(wbyte)) &&
    ((pin_o ^ value_r) & pin_oe_o) == 8'h00)
    else $error("value write not latched or driven");
  val_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_value) |=> $stable(value_r))
    else $error("latch changed without a write");
  dir_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dir) |=> dir_r == $past(wbyte))
    else $error("direction write not stored");
  dir_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_dir) |=> $stable(dir_r))
    else $error("direction changed without a write");
  pull_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_pull) |=> pull_r == $past(wbyte))
    else $error("pull write not stored");
  pull_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_pull) |=> $stable(pull_r))
    else $error("pull changed without a write");
  slew_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_slew) |=> slew_r == $past(wbyte))
    else $error("slew write not stored");
  slew_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_slew) |=> $stable(slew_r))
    else $error("slew changed without a write");
  drive_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_drive) |=> drive_r == $past(wbyte))
    else $error("drive write not stored");
  drive_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_drive) |=> $stable(drive_r))
    else $error("drive changed without a write");
  nosel_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && !wb_sel_i[0]) |=>
    $stable(value_r) && $stable(dir_r) && $stable(pull_r))
    else $error("write without lane select changed state");
  err_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !hit_any) |=> $stable(value_r) && $stable(dir_r) &&
    $stable(slew_r) && $stable(drive_r) && $stable(pull_r))
    else $error("refused access changed state");
  dir_bit1_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dir) |=> dir_r[1] == $past(wbyte[1]))
    else $error("direction bit one not stored");

  // register reads
  rd_bit1_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_value) |=> wb_ack_o && (wb_dat_o[1] == $past(level_r[1])))
    else $error("bit 1 read is not the pin level");
  rd_mix_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_value) |=> wb_dat_o[7:0] == $past(value_rd))
    else $error("value read mux wrong");
  rd_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_value) |=> ((wb_dat_o[7:0] ^ $past(value_r)) & $past(dir_eff)) == 8'h00)
    else $error("output bit read is not the latch");
  rd_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_value) |=> ((wb_dat_o[7:0] ^ $past(level_r)) & ~$past(dir_eff)) == 8'h00)
    else $error("input bit read is not the pin level");
  rd_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_dir) |=> wb_dat_o[7:0] == $past(dir_r))
    else $error("direction read wrong");
  rd_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_pull) |=> wb_dat_o[7:0] == $past(pull_r))
    else $error("pull read wrong");
  rd_slew_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_slew) |=> wb_dat_o[7:0] == $past(slew_r))
    else $error("slew read wrong");
  rd_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_drive) |=> wb_dat_o[7:0] == $past(drive_r))
    else $error("drive read wrong");

  // driver gating
  pin_oe_bit1_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pin_oe_o[1] && !slew_o[1] && !drive_o[1])
    else $error("input-only pin shows driver controls");
  out_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_o & ~pin_oe_o) == 8'h00)
    else $error("pin value without driver");
  pull_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pull_up_o & pin_oe_o) == 8'h00)
    else $error("pull-up on an output pin");
  pull_enab_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pull_up_o == (pull_r & ~pin_oe_o))
    else $error("pull-up does not follow enable");
  no_pulldown_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pull_down_o == 8'h00)
    else $error("pull-down applied");
  slew_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((slew_o | drive_o) & ~pin_oe_o) == 8'h00)
    else $error("slew or drive on input pin");
  pin1_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pin_o[1])
    else $error("input-only pin driven");
  dir_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dir) |=>
    (pull_up_o & $past(wbyte) & ~`GPE_IN_ONLY_MSK) == 8'h00)
    else $error("pull-up kept on new output");

  // pin mapping
  wr_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dir) |=> (pin_oe_o == ($past(wbyte) & ~`GPE_IN_ONLY_MSK)))
    else $error("direction write not on pins next edge");
  oe_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_oe_o == (dir_r & ~`GPE_IN_ONLY_MSK))
    else $error("driver enable does not follow direction");
  pin_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_o == (value_r & pin_oe_o))
    else $error("pin level does not follow latch");
  slew_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    slew_o == (slew_r & pin_oe_o))
    else $error("slew does not follow register");
  drive_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_o == (drive_r & pin_oe_o))
    else $error("drive does not follow register");
  pin1_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pull_up_o[1] == pull_r[1])
    else $error("input-only pin pull wrong");
  dir_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dir && wbyte == 8'h00) |=> pin_oe_o == 8'h00 && pin_o == 8'h00)
    else $error("pins still driven after clearing direction");

  // pin update timing
  val_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_value) |=> ((pin_o ^ $past(wbyte)) & pin_oe_o) == 8'h00)
    else $error("value write not on pins next edge");
  pull_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_pull) |=> pull_up_o == ($past(wbyte) & ~pin_oe_o))
    else $error("pull write not on pins next edge");
  slew_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_slew) |=> slew_o == ($past(wbyte) & pin_oe_o))
    else $error("slew write not on pins next edge");
  drive_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_drive) |=> drive_o == ($past(wbyte) & pin_oe_o))
    else $error("drive write not on pins next edge");
  out_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr |=> $stable(pin_oe_o) && $stable(pin_o))
    else $error("pin driver changed without a write");
  ctl_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr |=> $stable(pull_up_o) && $stable(slew_o) && $stable(drive_o))
    else $error("pin controls changed without a write");

  // input synchroniser
  level_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> ((level_r ^ $past(level_r)) & ($past(sync2_r) ^ $past(sync3_r))) == 8'h00)
    else $error("level moved while stages disagree");
  level_agree_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |->
    ((level_r ^ $past(sync2_r)) & ~($past(sync2_r) ^ $past(sync3_r))) == 8'h00)
    else $error("level ignores agreeing stages");

  // reset state
  rst_hiz_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> pin_oe_o == 8'h00 && pull_up_o == 8'h00 &&
    value_r == 8'h00)
    else $error("pins not released after reset");
  rst_regs_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> value_r == `GPE_RST_VALUE && dir_r == `GPE_RST_DIR &&
    pull_r == `GPE_RST_PULL && slew_r == `GPE_RST_SLEW &&
    drive_r == `GPE_RST_DRIVE)
    else $error("registers not cleared by reset");
  rst_pins_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> pin_oe_o == 8'h00 && pin_o == 8'h00 && pull_up_o == 8'h00)
    else $error("pins not high impedance after reset");
  rst_drvctl_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> slew_o == 8'h00 && drive_o == 8'h00)
    else $error("driver controls set after reset");
  rst_bus_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> !wb_ack_o && !wb_err_o)
    else $error("bus answer during reset");
  rst_sync_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> level_r == 8'h00 && sync3_r == 8'h00)
    else $error("synchroniser not cleared by reset");
endmodule
`default_nettype wire

// ---- verilog/gpe_regs.svh ----
// Notes on behaviour
// - input pin: value register read returns the synchronised pin level.
// - output pin: value register read returns the last written latch value.
// - every write to the value register with byte lane 0 selected lands in all eight latch bits.
// - output pin is driven with its latch bit.
// - reset clears the latch; its zeros reach a pin once that pin's direction bit is set.
// - after reset every pin is a high-impedance input, pull-up off.
// - bit 1 of the value register always reads the pin level.
// - direction 0 disables driver, reads pin; 1 enables driver, reads latch.
// - pin 1 input-only: its direction, slew and drive bits do nothing.
// - pull-enable bit 1 turns the pin's pull-up on, 0 off.
// - output pin: pull-enable ignored, pull devices off.
// - pull-down only with pin interrupt logic, absent here, so never applied.
// - slew bit enables slew control; no effect on input pins.
// - drive bit selects low (0) or high (1) drive; no effect on inputs.
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH
`define GPE_OFS_VALUE   8'h00
`define GPE_OFS_DIR     8'h04
`define GPE_OFS_PULL    8'h08
`define GPE_OFS_SLEW    8'h0c
`define GPE_OFS_DRIVE   8'h10
`define GPE_RST_VALUE   8'h00
`define GPE_RST_DIR     8'h00
`define GPE_RST_PULL    8'h00
`define GPE_RST_SLEW    8'h00
`define GPE_RST_DRIVE   8'h00
`define GPE_IN_ONLY_BIT 1
`define GPE_IN_ONLY_MSK 8'h02
`endif
